// file: common/dctp_defines.svh
// Register addresses, bit positions, reset values and prescale counts of the dual counter/timer pair
`ifndef DCTP_DEFINES_SVH
`define DCTP_DEFINES_SVH

// Register addresses on the special function register port
`define DCTP_ADDR_CTRL       8'h88
`define DCTP_ADDR_MODE       8'h89
`define DCTP_ADDR_LO0        8'h8a
`define DCTP_ADDR_LO1        8'h8b
`define DCTP_ADDR_HI0        8'h8c
`define DCTP_ADDR_HI1        8'h8d
`define DCTP_ADDR_SCALE      8'h8e
`define DCTP_ADDR_IRQ_MASK   8'ha8
`define DCTP_ADDR_EXT_CFG    8'he4

// Timer control register bit positions
`define DCTP_CTRL_OVF1       7
`define DCTP_CTRL_RUN1       6
`define DCTP_CTRL_OVF0       5
`define DCTP_CTRL_RUN0       4

// Interrupt mask register bit positions
`define DCTP_IRQ_EN0         1
`define DCTP_IRQ_EN1         3

// Clock scale register fields
`define DCTP_SCALE_LSB       0
`define DCTP_SCALE_MSB       1
`define DCTP_CLKSEL0         3
`define DCTP_CLKSEL1         4

// External interrupt config: gate polarity bits
`define DCTP_GATE_POL0       3
`define DCTP_GATE_POL1       7

// Mode register halves
`define DCTP_MODE1_LSB       4
`define DCTP_MODE0_LSB       0

// Reset values
`define DCTP_RST_BYTE        8'h00

// Prescale divide counts (system clock cycles per tick) for scale codes 0..3
`define DCTP_DIV_SCALE0      6'd12
`define DCTP_DIV_SCALE1      6'd4
`define DCTP_DIV_SCALE2      6'd48
`define DCTP_DIV_SCALE3      6'd8

`endif

// file: common/dctp_pkg.sv
// Types shared by the dual counter/timer pair
`default_nettype none
package dctp_pkg;

  // Operating mode of one timer
  typedef enum logic [1:0] {
    DCTP_M13    = 2'h0,  // 13-bit count
    DCTP_M16    = 2'h1,  // 16-bit count
    DCTP_M8RL   = 2'h2,  // 8-bit auto-reload
    DCTP_MSPLIT = 2'h3   // split / inactive
  } dctp_mode_t;

  // One nibble of the mode register
  typedef struct packed {
    logic       gate;     // Gate by external input
    logic       cnt_sel;  // 1: count external pin falls
    dctp_mode_t mode;     // Operating mode
  } dctp_tmode_t;

  // Register port request from the core
  typedef struct packed {
    logic       wr;       // One-cycle write strobe
    logic [7:0] addr;     // Register address
    logic [7:0] wdata;    // Write data
  } dctp_sfr_req_t;

  // External pins of both timers
  typedef struct packed {
    logic [1:0] count_pin;  // Count inputs, index = timer
    logic [1:0] gate_in;    // Gate inputs, index = timer
  } dctp_pins_t;

endpackage : dctp_pkg
`default_nettype wire

// file: core/dctp_core.sv
// Dual 16-bit counter/timer pair with its special function registers
// Behaviour
// R1 - Each timer is 16 bits, two bytes
// R2 - Mode 00 13-bit, 01 16-bit, 10 reload
// R3 - Second timer mode 11 stops counting
// R4 - First timer mode 11 splits into two
// R5 - 13-bit: high byte plus low five bits
// R6 - 13-bit wrap sets overflow flag, interrupt
// R7 - Counter select counts external pin falls
// R8 - Timer select: system or prescaled clock
// R9 - Count needs run and open gate
// R10 - Gate active level set by polarity bit
// R11 - Run bit never clears or reloads count
// R12 - Software loads count before setting run
// R13 - Second timer mirrors first with own resources
// R14 - Per-timer interrupt enable gates requests
// R15 - Mode register at 0x89, resets zero
// R16 - 16-bit mode wraps at 0xffff, flags
// R17 - Reload mode reloads low from high
// R18 - Pins synchronised, falls from two samples
`include "dctp_defines.svh"
`default_nettype none
module dctp_core (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Register port
  input  wire dctp_pkg::dctp_sfr_req_t sfr_req,
  output logic [7:0]                  sfr_rdata,
  // External count and gate pins
  input  wire dctp_pkg::dctp_pins_t   pins,
  // Interrupt requests
  output logic                        first_timer_irq,
  output logic                        second_timer_irq
);
  import dctp_pkg::*;
  // Reads come from a register, so software sees the state of the edge
  // before its address; no latch pairs the two count bytes, so a reader
  // that needs a coherent 16-bit value must re-read across a rollover

  // Register state
  logic [7:0]  timer_mode_select;       // Mode register
  logic [7:0]  timer_low [2];           // Low bytes, index = timer
  logic [7:0]  timer_high [2];          // High bytes, index = timer
  logic [1:0]  timer_run;               // Run bits
  logic [1:0]  timer_ovf;               // Overflow flags
  logic [1:0]  timer_irq_en;            // Interrupt enables
  logic [7:0]  clock_scale_control;     // Prescale and clock selects
  logic [1:0]  gate_polarity;           // Gate active levels
  logic [5:0]  prescale_cnt;            // Prescaler counter
  logic [7:0]  next_mode;
  logic [7:0]  next_low [2];
  logic [7:0]  next_high [2];
  logic [1:0]  next_run;
  logic [1:0]  next_ovf;
  logic [1:0]  next_irq_en;
  logic [7:0]  next_scale;
  logic [1:0]  next_pol;
  logic [5:0]  next_prescale;
  logic [7:0]  next_rdata;
  logic        next_irq0;
  logic        next_irq1;

  // Decoded per-timer controls
  dctp_tmode_t tmode [2];
  logic [1:0]  gate_level;              // Synchronised gate inputs
  logic [1:0]  pin_fall;                // Falling-edge pulses of count pins
  logic [1:0]  clk_sel;                 // 1: count every system clock
  logic [1:0]  enable;                  // Run and gate allow counting
  logic [1:0]  tick;                    // Count this cycle
  logic        prescale_tick;           // One pulse per prescale period
  logic        split0;                  // First timer in split mode
  logic        hi_tick;                 // Upper half of split first timer
  logic [5:0]  div_sel;                 // Selected prescale count

  // Mode nibbles decode straight from the register with no shadow copy,
  // so a mode write takes effect at the very next count step
  assign tmode[0] = dctp_tmode_t'(timer_mode_select[`DCTP_MODE0_LSB +: 4]);
  assign tmode[1] = dctp_tmode_t'(timer_mode_select[`DCTP_MODE1_LSB +: 4]);
  assign clk_sel  = {clock_scale_control[`DCTP_CLKSEL1], clock_scale_control[`DCTP_CLKSEL0]};
  assign split0   = (tmode[0].mode == DCTP_MSPLIT);

  // Synchronise both count pins and both gate inputs
  // Gate inputs pass the same two flops as the count pins, so a gate
  // change reaches the enable two edges after the pin moves
  for (genvar g = 0; g < 2; g++) begin : g_pins
    dctp_edge_sync u_count_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .pin   (pins.count_pin[g]),
      .level (),
      .fall  (pin_fall[g])
    );
    dctp_edge_sync u_gate_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .pin   (pins.gate_in[g]),
      .level (gate_level[g]),
      .fall  ()
    );
  end

  // One count step: returns {overflow, high, low}
  // Split mode (default branch) steps only the low byte; the caller keeps
  // the high byte for the upper half, which has its own increment
  function automatic logic [16:0] dctp_step(input dctp_mode_t m, input logic [7:0] lo, input logic [7:0] hi);
    logic [12:0] c13;
    logic [15:0] c16;
    c13 = {hi, lo[4:0]} + 13'h0001;
    c16 = {hi, lo} + 16'h0001;
    case (m)  // R2
      // Upper three low bits are left alone; they carry no count
      DCTP_M13:  dctp_step = {({hi, lo[4:0]} == 13'h1fff), c13[12:5], lo[7:5], c13[4:0]};  // R5 R6
      DCTP_M16:  dctp_step = {(c16 == 16'h0000), c16};  // R16
      DCTP_M8RL: begin
        if (lo == 8'hff) begin
          dctp_step = {1'b1, hi, hi};  // R17
        end else begin
          dctp_step = {1'b0, hi, lo + 8'h01};
        end
      end
      default:   dctp_step = {(lo == 8'hff), hi, lo + 8'h01};  // R4
    endcase
  endfunction : dctp_step

  // Prescale period for a scale code
  function automatic logic [5:0] dctp_div(input logic [1:0] code);
    case (code)
      2'h0:    dctp_div = `DCTP_DIV_SCALE0;
      2'h1:    dctp_div = `DCTP_DIV_SCALE1;
      2'h2:    dctp_div = `DCTP_DIV_SCALE2;
      default: dctp_div = `DCTP_DIV_SCALE3;
    endcase
  endfunction : dctp_div

  // Prescaler: wraps at the selected period; a scale change takes effect within one period
  // One prescaler serves both timers and runs from reset whether or not a
  // timer uses it, so the first prescaled tick after a run bit is set may
  // come anywhere within one period
  always_comb begin
    div_sel = dctp_div(clock_scale_control[`DCTP_SCALE_MSB:`DCTP_SCALE_LSB]);
    prescale_tick = (prescale_cnt >= div_sel - 6'h01);
    next_prescale = prescale_tick ? 6'h00 : prescale_cnt + 6'h01;
  end

  // Count enables and count sources per timer
  // A pin fall while the gate is closed is lost, not held for later
  always_comb begin
    for (int t = 0; t < 2; t++) begin
      // Gate input counts as active when it equals its polarity bit
      enable[t] = timer_run[t] & (~tmode[t].gate | (gate_level[t] == gate_polarity[t]));  // R9 R10 R13
      if (tmode[t].cnt_sel) begin
        tick[t] = enable[t] & pin_fall[t];  // R7
      end else begin
        tick[t] = enable[t] & (clk_sel[t] | prescale_tick);  // R8
      end
    end
    // Second timer does nothing in mode 11
    if (tmode[1].mode == DCTP_MSPLIT) begin
      tick[1] = 1'b0;  // R3
    end
    // Split upper half runs as a timer under the second run bit
    hi_tick = split0 & timer_run[1] & (clk_sel[0] | prescale_tick);  // R4
  end

  // Register writes, counting and flag updates
  always_comb begin
    logic [16:0] s0;
    logic [16:0] s1;
    logic [7:0]  hi0_inc;
    s0 = dctp_step(tmode[0].mode, timer_low[0], timer_high[0]);
    s1 = dctp_step(tmode[1].mode, timer_low[1], timer_high[1]);
    hi0_inc = timer_high[0] + 8'h01;
    next_mode   = timer_mode_select;
    next_run    = timer_run;
    next_ovf    = timer_ovf;
    next_irq_en = timer_irq_en;
    next_scale  = clock_scale_control;
    next_pol    = gate_polarity;
    next_low    = timer_low;
    next_high   = timer_high;

    // Count steps; a run-bit change alone never touches the count
    if (tick[0]) begin
      next_low[0] = s0[7:0];  // R1 R11
      if (!split0) begin
        next_high[0] = s0[15:8];
      end
    end
    if (hi_tick) begin
      next_high[0] = hi0_inc;  // R4
    end
    if (tick[1]) begin
      next_low[1]  = s1[7:0];  // R1 R13
      next_high[1] = s1[15:8];
    end

    // Software writes; a byte written this cycle wins over its count
    // Only the byte written is overridden; the other byte keeps this
    // cycle's count step, which can tear a carry across the pair
    if (sfr_req.wr) begin
      if (sfr_req.addr == `DCTP_ADDR_MODE) begin
        next_mode = sfr_req.wdata;  // R15
      end else if (sfr_req.addr == `DCTP_ADDR_LO0) begin
        next_low[0] = sfr_req.wdata;
      end else if (sfr_req.addr == `DCTP_ADDR_LO1) begin
        next_low[1] = sfr_req.wdata;
      end else if (sfr_req.addr == `DCTP_ADDR_HI0) begin
        next_high[0] = sfr_req.wdata;
      end else if (sfr_req.addr == `DCTP_ADDR_HI1) begin
        next_high[1] = sfr_req.wdata;
      end else if (sfr_req.addr == `DCTP_ADDR_CTRL) begin
        next_run = {sfr_req.wdata[`DCTP_CTRL_RUN1], sfr_req.wdata[`DCTP_CTRL_RUN0]};  // R11
        next_ovf = {sfr_req.wdata[`DCTP_CTRL_OVF1], sfr_req.wdata[`DCTP_CTRL_OVF0]};
      end else if (sfr_req.addr == `DCTP_ADDR_IRQ_MASK) begin
        next_irq_en = {sfr_req.wdata[`DCTP_IRQ_EN1], sfr_req.wdata[`DCTP_IRQ_EN0]};  // R14
      end else if (sfr_req.addr == `DCTP_ADDR_SCALE) begin
        next_scale = sfr_req.wdata;
      end else if (sfr_req.addr == `DCTP_ADDR_EXT_CFG) begin
        next_pol = {sfr_req.wdata[`DCTP_GATE_POL1], sfr_req.wdata[`DCTP_GATE_POL0]};  // R10
      end
    end

    // Overflow sets come last so a same-cycle software clear loses
    // A flag write of one also sets the flag; only software clears it
    if (tick[0] && s0[16]) begin
      next_ovf[0] = 1'b1;  // R6 R16 R17
    end
    // In split mode the upper half owns the second flag
    if (hi_tick && (timer_high[0] == 8'hff)) begin
      next_ovf[1] = 1'b1;  // R4
    end
    if (tick[1] && s1[16] && !split0) begin
      next_ovf[1] = 1'b1;  // R13
    end
  end

  // Read mux and interrupt requests; all reads are free of side effects
  // Unused bits and unmapped addresses read as zero, except the scale register, which reads back all eight bits as written
  always_comb begin
    next_rdata = 8'h00;
    if (sfr_req.addr == `DCTP_ADDR_MODE) begin
      next_rdata = timer_mode_select;
    end else if (sfr_req.addr == `DCTP_ADDR_LO0) begin
      next_rdata = timer_low[0];
    end else if (sfr_req.addr == `DCTP_ADDR_LO1) begin
      next_rdata = timer_low[1];
    end else if (sfr_req.addr == `DCTP_ADDR_HI0) begin
      next_rdata = timer_high[0];
    end else if (sfr_req.addr == `DCTP_ADDR_HI1) begin
      next_rdata = timer_high[1];
    end else if (sfr_req.addr == `DCTP_ADDR_CTRL) begin
      next_rdata[`DCTP_CTRL_OVF1] = timer_ovf[1];
      next_rdata[`DCTP_CTRL_RUN1] = timer_run[1];
      next_rdata[`DCTP_CTRL_OVF0] = timer_ovf[0];
      next_rdata[`DCTP_CTRL_RUN0] = timer_run[0];
    end else if (sfr_req.addr == `DCTP_ADDR_IRQ_MASK) begin
      next_rdata[`DCTP_IRQ_EN1] = timer_irq_en[1];
      next_rdata[`DCTP_IRQ_EN0] = timer_irq_en[0];
    end else if (sfr_req.addr == `DCTP_ADDR_SCALE) begin
      next_rdata = clock_scale_control;
    end else if (sfr_req.addr == `DCTP_ADDR_EXT_CFG) begin
      next_rdata[`DCTP_GATE_POL1] = gate_polarity[1];
      next_rdata[`DCTP_GATE_POL0] = gate_polarity[0];
    end
    // Requests follow the next flag value so they line up with the flag
    next_irq0 = next_ovf[0] & next_irq_en[0];  // R14
    next_irq1 = next_ovf[1] & next_irq_en[1];  // R14
  end

  // Register all state
  // Reset is synchronous, so every register sits in one process and the
  // reset branch assigns nothing but constants
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_mode_select   <= `DCTP_RST_BYTE;  // R15
      timer_low[0]        <= `DCTP_RST_BYTE;
      timer_low[1]        <= `DCTP_RST_BYTE;
      timer_high[0]       <= `DCTP_RST_BYTE;
      timer_high[1]       <= `DCTP_RST_BYTE;
      timer_run           <= 2'h0;
      timer_ovf           <= 2'h0;
      timer_irq_en        <= 2'h0;
      clock_scale_control <= `DCTP_RST_BYTE;
      gate_polarity       <= 2'h0;
      prescale_cnt        <= 6'h00;
      sfr_rdata           <= 8'h00;
      first_timer_irq     <= 1'b0;
      second_timer_irq    <= 1'b0;
    end else begin
      timer_mode_select   <= next_mode;
      timer_low           <= next_low;
      timer_high          <= next_high;
      timer_run           <= next_run;
      timer_ovf           <= next_ovf;
      timer_irq_en        <= next_irq_en;
      clock_scale_control <= next_scale;
      gate_polarity       <= next_pol;
      prescale_cnt        <= next_prescale;
      sfr_rdata           <= next_rdata;
      first_timer_irq     <= next_irq0;
      second_timer_irq    <= next_irq1;
    end
  end

endmodule : dctp_core
`default_nettype wire

// file: core/dctp_edge_sync.sv
// Two-flop synchroniser with falling-edge detection for one external pin
`default_nettype none
module dctp_edge_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Raw pin
  input  wire logic pin,
  // Synchronised level and falling-edge pulse
  output logic      level,
  output logic      fall
);

  logic meta;        // First stage, read only by the second stage
  logic sync;        // Second stage, safe to use
  logic hist;        // Previous synchronised sample
  logic next_meta;
  logic next_sync;
  logic next_hist;

  // Next values of the chain
  always_comb begin
    next_meta = pin;
    next_sync = meta;
    next_hist = sync;
  end

  // Register the chain; reset to high so a high pin at start is not a fall; a low one gives one fall
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= 1'b1;
      sync <= 1'b1;
      hist <= 1'b1;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      hist <= next_hist;
    end
  end

  assign level = sync;
  // Fall seen across two successive synchronised samples
  assign fall  = hist & ~sync;  // R18

endmodule : dctp_edge_sync
`default_nettype wire

// file: tb/dctp_core_assertions.sv
// Checker on the ports of the counter/timer pair
`include "dctp_defines.svh"
`default_nettype none
module dctp_core_assertions (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst_n,
  // Register port
  input wire dctp_pkg::dctp_sfr_req_t sfr_req,
  input wire logic [7:0]             sfr_rdata,
  // Pins and interrupts
  input wire dctp_pkg::dctp_pins_t   pins,
  input wire logic                   first_timer_irq,
  input wire logic                   second_timer_irq
);
  logic [7:0] mode_sh;       // Shadow of the mode register
  logic [7:0] next_mode_sh;  // Its next value
  logic       run_sh;        // Shadow of the first run bit
  logic       next_run_sh;   // Its next value
  // Hardware never changes these bits, so writes alone track them
  always_comb begin
    next_mode_sh = mode_sh;
    next_run_sh = run_sh;
    if (sfr_req.wr && sfr_req.addr == `DCTP_ADDR_MODE)
      next_mode_sh = sfr_req.wdata;
    if (sfr_req.wr && sfr_req.addr == `DCTP_ADDR_CTRL)
      next_run_sh = sfr_req.wdata[`DCTP_CTRL_RUN0];
  end
  // Shadow registers
  always_ff @(posedge clk) begin
    mode_sh <= rst_n ? next_mode_sh : 8'h00;
    run_sh <= rst_n & next_run_sh;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  reset_irq_a: assert property (disable iff (1'b0) !rst_n |=> !first_timer_irq && !second_timer_irq)
    else $error("interrupt high after reset");
  mode_readback_a: assert property (sfr_req.wr && sfr_req.addr == `DCTP_ADDR_MODE
    ##1 !sfr_req.wr && sfr_req.addr == `DCTP_ADDR_MODE |=> sfr_rdata == $past(sfr_req.wdata, 2))
    else $error("mode register readback wrong");
  irq0_flag_a: assert property (sfr_req.addr == `DCTP_ADDR_CTRL && first_timer_irq
    |=> sfr_rdata[`DCTP_CTRL_OVF0]) else $error("first interrupt without flag");
  irq1_flag_a: assert property (sfr_req.addr == `DCTP_ADDR_CTRL && second_timer_irq
    |=> sfr_rdata[`DCTP_CTRL_OVF1]) else $error("second interrupt without flag");
  mask0_off_a: assert property (sfr_req.wr && sfr_req.addr == `DCTP_ADDR_IRQ_MASK
    && !sfr_req.wdata[`DCTP_IRQ_EN0] |=> !first_timer_irq) else $error("masked first interrupt");
  mask1_off_a: assert property (sfr_req.wr && sfr_req.addr == `DCTP_ADDR_IRQ_MASK
    && !sfr_req.wdata[`DCTP_IRQ_EN1] |=> !second_timer_irq) else $error("masked second interrupt");
  idle1_frozen_a: assert property (mode_sh[5:4] == 2'h3 && sfr_req.addr == `DCTP_ADDR_LO1
    && !sfr_req.wr ##1 sfr_req.addr == `DCTP_ADDR_LO1 && !sfr_req.wr |=> $stable(sfr_rdata))
    else $error("inactive second timer moved");
  stop0_frozen_a: assert property (!run_sh && sfr_req.addr == `DCTP_ADDR_LO0
    && !sfr_req.wr ##1 sfr_req.addr == `DCTP_ADDR_LO0 && !sfr_req.wr |=> $stable(sfr_rdata))
    else $error("stopped first timer moved");
endmodule : dctp_core_assertions
bind dctp_core dctp_core_assertions u_chk (.clk(clk), .rst_n(rst_n), .sfr_req(sfr_req),
  .sfr_rdata(sfr_rdata), .pins(pins), .first_timer_irq(first_timer_irq),
  .second_timer_irq(second_timer_irq));
`default_nettype wire

// file: tb/dctp_pin_model.sv
// Behavioural driver of the external count and gate pins
`default_nettype none
module dctp_pin_model (
  // Clock
  input  wire logic                 clk,
  // Pins toward the core
  output var  dctp_pkg::dctp_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // Count pins idle high, so release from reset is never a fall
  initial pins = '{count_pin: 2'h3, gate_in: 2'h0};
  // One fall on pin t; w sets prompt or slow phases
  task automatic fall(input int t, input int w);
    pins.count_pin[t] = 1'b0;
    repeat (w) @(posedge clk);
    #1 pins.count_pin[t] = 1'b1;
    repeat (w) @(posedge clk);
    #1;
  endtask : fall
  // Gate levels for both timers
  task automatic gate(input logic [1:0] g);
    pins.gate_in = g;
  endtask : gate
endmodule : dctp_pin_model
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the dual counter/timer pair
`include "dctp_defines.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk, rst_n;      // Clock and reset
  dctp_pkg::dctp_sfr_req_t req;             // Register port request
  dctp_pkg::dctp_pins_t    pins;            // External pins
  logic [7:0]              rdata, h, l, v;  // Read data and model bytes
  logic                    irq0, irq1, rd_v, seen, f, c;
  logic [15:0]             m, q_exp [$];    // Notes of {mask, value}
  int                      num_errors, check_count, n;
  int                      seed = 32'h6594;
  logic [7:0] regs [10] = '{`DCTP_ADDR_CTRL, `DCTP_ADDR_MODE, `DCTP_ADDR_LO0, `DCTP_ADDR_LO1,
    `DCTP_ADDR_HI0, `DCTP_ADDR_HI1, `DCTP_ADDR_SCALE, `DCTP_ADDR_IRQ_MASK, `DCTP_ADDR_EXT_CFG, 8'h00};
  dctp_core dut (.clk(clk), .rst_n(rst_n), .sfr_req(req), .sfr_rdata(rdata), .pins(pins),
    .first_timer_irq(irq0), .second_timer_irq(irq1));
  dctp_pin_model pm (.clk(clk), .pins(pins));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare seen against expected, count both
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // Wait k edges, then step just past the edge
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  // Write takes two cycles so the strobe is never re-raised at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, addr: a, wdata: d};
    tick(1);
    req.wr = 1'b0;
    tick(1);
  endtask : wr
  // Address held two edges; note the expectation for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] mk);
    req.addr = a;
    rd_v = 1'b1;
    q_exp.push_back({mk, e & mk});
    tick(1);
    rd_v = 1'b0;
    tick(1);
  endtask : rd
  // Read data settles one edge after the address; look mid-cycle
  always @(posedge clk) seen <= rd_v;
  always @(negedge clk) begin
    if (seen === 1'b1) begin
      m = q_exp.pop_front();
      check(rdata & m[15:8], m[7:0]);
    end
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    close_out();
  end
  initial begin
    rst_n = 1'b0;
    req = '0;
    rd_v = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    wr(8'h00, 8'hff);
    foreach (regs[i]) rd(regs[i], 8'h00, 8'hff);
    v = 8'($random(seed));
    wr(`DCTP_ADDR_MODE, v);
    rd(`DCTP_ADDR_MODE, v, 8'hff);
    $display("test registers done");
    // Modes 00 to 10 on each timer from a loaded start near overflow
    wr(`DCTP_ADDR_SCALE, 8'h18);
    for (int t = 0; t < 2; t++) begin
      for (int md = 0; md < 3; md++) begin
        n = 3 + ($random(seed) & 3);
        l = 8'hf8 | 8'($random(seed));
        h = (md == 2) ? 8'($random(seed)) : 8'hff;
        wr(`DCTP_ADDR_MODE, 8'(md << (4 * t)));
        wr(8'(`DCTP_ADDR_LO0 + t), l);
        wr(8'(`DCTP_ADDR_HI0 + t), h);
        wr(`DCTP_ADDR_IRQ_MASK, 8'h0a);
        wr(`DCTP_ADDR_CTRL, 8'(8'h10 << (2 * t)));
        tick(n - 2);
        // Counter select with idle pins stops the count, flag untouched
        wr(`DCTP_ADDR_MODE, 8'((md | 4) << (4 * t)));
        f = 1'b0;
        repeat (n) begin
          c = 1'b0;
          case (md)
            0: {c, h, l[4:0]} = {h, l[4:0]} + 13'h1;
            1: {c, h, l} = {h, l} + 16'h1;
            default: begin
              c = (l == 8'hff);
              l = c ? h : l + 8'h1;
            end
          endcase
          f |= c;
        end
        rd(`DCTP_ADDR_CTRL, 8'({f, 1'b1, 4'h0}) << (2 * t), 8'hff);
        check({7'h0, t ? irq1 : irq0}, {7'h0, f});
        wr(`DCTP_ADDR_IRQ_MASK, 8'h00);
        check({7'h0, t ? irq1 : irq0}, 8'h00);
        wr(`DCTP_ADDR_CTRL, 8'h00);
        rd(8'(`DCTP_ADDR_LO0 + t), l, (md == 0) ? 8'h1f : 8'hff);
        rd(8'(`DCTP_ADDR_HI0 + t), h, 8'hff);
      end
    end
    $display("test modes done");
    // Pin falls, prompt and slow, drive both counters
    wr(`DCTP_ADDR_MODE, 8'h55);
    wr(`DCTP_ADDR_LO0, 8'h00);
    wr(`DCTP_ADDR_LO1, 8'h00);
    wr(`DCTP_ADDR_CTRL, 8'h50);
    repeat (3) begin
      pm.fall(0, 2);
      pm.fall(1, 5);
    end
    tick(4);
    wr(`DCTP_ADDR_CTRL, 8'h00);
    rd(`DCTP_ADDR_LO0, 8'h03, 8'hff);
    rd(`DCTP_ADDR_LO1, 8'h03, 8'hff);
    $display("test pins done");
    // Gates active high for one timer and active low for the other
    wr(`DCTP_ADDR_EXT_CFG, 8'h08);
    wr(`DCTP_ADDR_MODE, 8'h99);
    for (int act = 0; act < 2; act++) begin
      pm.gate(act ? 2'b01 : 2'b10);
      wr(`DCTP_ADDR_LO0, 8'h00);
      wr(`DCTP_ADDR_LO1, 8'h00);
      wr(`DCTP_ADDR_CTRL, 8'h50);
      tick(2);
      wr(`DCTP_ADDR_CTRL, 8'h00);
      rd(`DCTP_ADDR_LO0, 8'(4 * act), 8'hff);
      rd(`DCTP_ADDR_LO1, 8'(4 * act), 8'hff);
    end
    $display("test gates done");
    // Split lower timer runs twice over; upper timer parked
    wr(`DCTP_ADDR_MODE, 8'h33);
    for (int i = 0; i < 4; i++) wr(8'(`DCTP_ADDR_LO0 + i), 8'(16 * i + 16));
    wr(`DCTP_ADDR_CTRL, 8'h50);
    // Parked upper timer read while its run bit is set
    rd(`DCTP_ADDR_LO1, 8'h20, 8'hff);
    tick(1);
    wr(`DCTP_ADDR_CTRL, 8'h00);
    for (int i = 0; i < 4; i++) rd(8'(`DCTP_ADDR_LO0 + i), 8'(16 * i + 16 + ((i % 2) ? 0 : 5)), 8'hff);
    $display("test split done");
    // Reset with both timers stopped and a flag and its request raised
    wr(`DCTP_ADDR_IRQ_MASK, 8'h02);
    wr(`DCTP_ADDR_CTRL, 8'h20);
    check({7'h0, irq0}, 8'h01);
    rst_n = 1'b0;
    tick(3);
    rst_n = 1'b1;
    rd(`DCTP_ADDR_MODE, 8'h00, 8'hff);
    rd(`DCTP_ADDR_CTRL, 8'h00, 8'hff);
    rd(`DCTP_ADDR_LO0, 8'h00, 8'hff);
    check({7'h0, irq0}, 8'h00);
    $display("test reset done");
    // Prescaled clock on both timers; 24 counted edges span whole periods
    wr(`DCTP_ADDR_MODE, 8'h11);
    for (int s = 0; s < 2; s++) begin
      wr(`DCTP_ADDR_SCALE, 8'(s));
      wr(`DCTP_ADDR_LO0, 8'h00);
      wr(`DCTP_ADDR_LO1, 8'h00);
      wr(`DCTP_ADDR_CTRL, 8'h50);
      tick(22);
      wr(`DCTP_ADDR_CTRL, 8'h00);
      v = 8'(24 / (s ? `DCTP_DIV_SCALE1 : `DCTP_DIV_SCALE0));
      rd(`DCTP_ADDR_LO0, v, 8'hff);
      rd(`DCTP_ADDR_LO1, v, 8'hff);
    end
    $display("test prescale done");
    tick(2);
    close_out();
  end
endmodule : testbench
`default_nettype wire
